// file: design/cam_counter_aux_measure_compare.sv
// counter auxiliary block: width measure, sampling, single compare, irq routing
// What this block does
// - four independent width channels 0..3, each with counter and result.
// - polarity bit high measures high pulses, low measures low pulses.
// - width result is unsigned, in units of 0.01us.
// - enable and polarity fields use low four bits, bit n for channel n.
// - width and sampling channels run only while their enable is high.
// - eight compare interrupt outputs, one source-select bit each.
// - select bit 1 routes multi-compare point n of selected counter.
// - select bit 0 routes single-compare match output n.
// - counter-select 0..3 picks the counter driving multi-compare irqs.
// - sampling counts channel pulses within a programmed window.
// - sampling counts each cycle its count_pulse input is high, one event a cycle.
// - window length is a 32-bit value in microseconds.
// - sampled pulse count is reported unsigned.
// - single compare loads parameters on enable rise, idle while low.
// - compare output selector takes values 0 to 7.
// - width measurement uses four dedicated input pins, one per channel.
// - match output high while counter equals compare value, either way.
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
module cam_counter_aux_measure_compare (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [cam_pkg::CAM_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [cam_pkg::CAM_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [cam_pkg::CAM_WCH-1:0] width_pulse_input,
    input wire logic [cam_pkg::CAM_SCH-1:0] count_pulse,
    input wire logic [cam_pkg::CAM_NCMP-1:0][31:0] counter_value,
    input wire logic [cam_pkg::CAM_NMCNT-1:0][7:0] multi_match,
    output logic [cam_pkg::CAM_NCMP-1:0] count_match_flag,
    output logic [cam_pkg::CAM_NCMP-1:0] compare_irq
);
    import cam_pkg::*;

    logic [CAM_WCH-1:0] pin_meta_r;
    logic [CAM_WCH-1:0] pin_sync_r;
    logic [CAM_WCH-1:0] width_channel_enable_r;
    logic [CAM_WCH-1:0] width_polarity_select_r;
    logic [CAM_WCH-1:0][31:0] width_result;
    logic [7:0] compare_irq_source_mask_r;
    logic [1:0] multi_compare_counter_select_r;
    logic [CAM_SCH-1:0] sampling_channel_enable_r;
    logic [CAM_SCH-1:0][31:0] sampling_window_length_r;
    logic [CAM_SCH-1:0][31:0] samp_result;
    logic [CAM_SCH-1:0] samp_done;
    logic [CAM_SCH-1:0] samp_flag_r;
    logic [CAM_SCH-1:0] samp_flag_clr;
    logic cmp_en_r;
    logic cmp_en_d_r;
    logic [2:0] cmp_ctr_r;
    logic [2:0] compare_output_select_r;
    logic [31:0] cmp_val_r;
    logic [2:0] act_ctr_r;
    logic [2:0] act_out_r;
    logic [31:0] act_val_r;
    logic aw_got_r;
    logic w_got_r;
    logic [CAM_ADDR_W-1:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic [CAM_ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [31:0] wr_word;
    logic do_wr;
    logic [32:0] wr_rd;
    logic [32:0] ar_rd;
    logic ar_hs;

    // register readback and address decode
    function automatic logic [32:0] reg_read(input logic [7:0] a);
        logic [32:0] r;
        r = {1'b1, CAM_RST_WORD};
        unique case (a)
            CAM_OFF_WCFG: begin
                r[31:0] = (32'(width_channel_enable_r) << CAM_WCFG_EN_LSB)
                    | (32'(width_polarity_select_r) << CAM_WCFG_POL_LSB);
            end
            CAM_OFF_ROUTE: begin
                r[31:0] = (32'(compare_irq_source_mask_r)
                    << CAM_ROUTE_MASK_LSB)
                    | (32'(multi_compare_counter_select_r)
                    << CAM_ROUTE_CSEL_LSB);
            end
            CAM_OFF_SCTRL: r[31:0] = 32'(sampling_channel_enable_r);
            CAM_OFF_SSTAT: r[31:0] = 32'(samp_flag_r);
            CAM_OFF_CCTRL: begin
                r[31:0] = (32'(cmp_en_r) << CAM_CCTRL_EN_BIT)
                    | (32'(cmp_ctr_r) << CAM_CCTRL_CTR_LSB)
                    | (32'(compare_output_select_r) << CAM_CCTRL_OUT_LSB);
            end
            CAM_OFF_CVAL: r[31:0] = cmp_val_r;
            CAM_OFF_CSTAT: r[31:0] = 32'(count_match_flag);
            default: r[32] = 1'b0;
        endcase
        for (int i = 0; i < 4; i++) begin
            if (a == CAM_OFF_WRES0 + 8'(4 * i)) begin
                r = {1'b1, width_result[i]};
            end
            if (a == CAM_OFF_SWIN0 + 8'(4 * i)) begin
                r = {1'b1, sampling_window_length_r[i]};
            end
            if (a == CAM_OFF_SRES0 + 8'(4 * i)) begin
                r = {1'b1, samp_result[i]};
            end
        end
        return r;
    endfunction : reg_read

    // width pins cross into the clock domain through two flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end else begin
            pin_meta_r <= width_pulse_input;
            pin_sync_r <= pin_meta_r;
        end
    end

    // write channel: address and data taken in either order
    assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
    assign s_axi_wready = !w_got_r && !s_axi_bvalid;
    assign wr_addr = aw_got_r ? aw_addr_r : s_axi_awaddr;
    assign wr_data = w_got_r ? w_data_r : s_axi_wdata;
    assign wr_strb = w_got_r ? w_strb_r : s_axi_wstrb;
    assign do_wr = (aw_got_r || s_axi_awvalid) && (w_got_r || s_axi_wvalid)
        && !s_axi_bvalid;
    always_comb begin
        wr_rd = reg_read(wr_addr);
        ar_rd = reg_read(s_axi_araddr);
    end
    assign wr_word = cam_merge(wr_rd[31:0], wr_data, wr_strb);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else if (do_wr) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= CAM_RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_rd[32] ? CAM_RESP_OKAY : CAM_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // software registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            width_channel_enable_r <= '0;
            width_polarity_select_r <= '0;
            compare_irq_source_mask_r <= 8'h00;
            multi_compare_counter_select_r <= 2'h0;
            sampling_channel_enable_r <= '0;
            sampling_window_length_r <= '0;
            cmp_en_r <= 1'b0;
            cmp_ctr_r <= 3'h0;
            compare_output_select_r <= 3'h0;
            cmp_val_r <= 32'h0000_0000;
        end else if (do_wr) begin
            if (wr_addr == CAM_OFF_WCFG) begin
                width_channel_enable_r <= wr_word[CAM_WCFG_EN_LSB +: 4];
                width_polarity_select_r <= wr_word[CAM_WCFG_POL_LSB +: 4];
            end
            if (wr_addr == CAM_OFF_ROUTE) begin
                compare_irq_source_mask_r <=
                    wr_word[CAM_ROUTE_MASK_LSB +: 8];
                multi_compare_counter_select_r <=
                    wr_word[CAM_ROUTE_CSEL_LSB +: 2];
            end
            if (wr_addr == CAM_OFF_SCTRL) begin
                sampling_channel_enable_r <= wr_word[CAM_SCH-1:0];
            end
            for (int i = 0; i < CAM_SCH; i++) begin
                if (wr_addr == CAM_OFF_SWIN0 + 8'(4 * i)) begin
                    // taken at once; stop the channel first to avoid a bad window
                    sampling_window_length_r[i] <= wr_word;
                end
            end
            if (wr_addr == CAM_OFF_CCTRL) begin
                cmp_en_r <= wr_word[CAM_CCTRL_EN_BIT];
                cmp_ctr_r <= wr_word[CAM_CCTRL_CTR_LSB +: 3];
                compare_output_select_r <=
                    wr_word[CAM_CCTRL_OUT_LSB +: 3];
            end
            if (wr_addr == CAM_OFF_CVAL) begin
                cmp_val_r <= wr_word;
            end
        end
    end

    // sampling done flags: set wins over write-one-to-clear
    always_comb begin
        samp_flag_clr = '0;
        if (do_wr && wr_addr == CAM_OFF_SSTAT && wr_strb[0]) begin
            samp_flag_clr = wr_data[CAM_SCH-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            samp_flag_r <= '0;
        end else begin
            samp_flag_r <= (samp_flag_r & ~samp_flag_clr) | samp_done;
        end
    end

    // read channel
    assign s_axi_arready = !s_axi_rvalid;
    assign ar_hs = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= CAM_RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= ar_rd[31:0];
            s_axi_rresp <= ar_rd[32] ? CAM_RESP_OKAY : CAM_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // width and sampling channels
    for (genvar g = 0; g < CAM_WCH; g++) begin : g_width
        cam_width_measure_unit u_width (
            .aclk(aclk),
            .aresetn(aresetn),
            .enable(width_channel_enable_r[g]),
            .polarity(width_polarity_select_r[g]),
            .pin_level(pin_sync_r[g]),
            .result(width_result[g])
        );
    end

    for (genvar g = 0; g < CAM_SCH; g++) begin : g_samp
        cam_timed_sampling_unit u_samp (
            .aclk(aclk),
            .aresetn(aresetn),
            .enable(sampling_channel_enable_r[g]),
            .window_us(sampling_window_length_r[g]),
            .count_event(count_pulse[g]),
            .result(samp_result[g]),
            .done(samp_done[g])
        );
    end

    // single compare: parameters loaded on enable rising edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_en_d_r <= 1'b0;
            act_ctr_r <= 3'h0;
            act_out_r <= 3'h0;
            act_val_r <= 32'h0000_0000;
        end else begin
            cmp_en_d_r <= cmp_en_r;
            if (cmp_en_r && !cmp_en_d_r) begin
                act_ctr_r <= cmp_ctr_r;
                act_out_r <= compare_output_select_r;
                act_val_r <= cmp_val_r;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_match_flag <= '0;
        end else begin
            count_match_flag <= '0;
            if (cmp_en_r && cmp_en_d_r) begin
                count_match_flag[act_out_r] <=
                    (counter_value[act_ctr_r] == act_val_r);
            end
        end
    end

    // interrupt routing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare_irq <= '0;
        end else begin
            for (int n = 0; n < CAM_NCMP; n++) begin
                compare_irq[n] <= compare_irq_source_mask_r[n]
                    ? multi_match[multi_compare_counter_select_r][n]
                    : count_match_flag[n];
            end
        end
    end

    sequence cmp_rise_s;
        !cmp_en_r ##1 cmp_en_r;
    endsequence

    cmp_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cmp_rise_s |=> (act_val_r == $past(cmp_val_r)
            && act_out_r == $past(compare_output_select_r)))
        else $error("compare parameters not taken on enable rise");
    cmp_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !cmp_en_r |=> (count_match_flag == '0))
        else $error("match flag set while compare disabled");
    cmp_match_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (cmp_en_r && cmp_en_d_r && counter_value[act_ctr_r] == act_val_r)
        |=> count_match_flag[act_out_r])
        else $error("match flag missing on equal count");
    for (genvar n = 0; n < CAM_NCMP; n++) begin : g_chk
        route_multi_a: assert property (@(posedge aclk)
            disable iff (!aresetn)
            (compare_irq_source_mask_r[n]
             && multi_match[multi_compare_counter_select_r][n])
            |=> compare_irq[n])
            else $error("multi compare point not routed");
        route_single_a: assert property (@(posedge aclk)
            disable iff (!aresetn)
            (!compare_irq_source_mask_r[n] && !count_match_flag[n])
            |=> !compare_irq[n])
            else $error("single compare irq raised without match");
    end
    bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_bvalid && !s_axi_bready) |=> $stable(s_axi_bvalid)
            && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
    rd_unmapped_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_hs && !ar_rd[32])
        |=> (s_axi_rvalid && s_axi_rresp == CAM_RESP_SLVERR))
        else $error("unmapped read not answered with error");
    samp_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (samp_done != '0) |=> ((samp_flag_r & $past(samp_done))
            == $past(samp_done)))
        else $error("sampling done flag lost");
endmodule : cam_counter_aux_measure_compare

// file: design/cam_pkg.sv
// constants, register map and helpers shared by the measure/compare block
package cam_pkg;
    localparam int CAM_WCH = 4;
    localparam int CAM_SCH = 4;
    localparam int CAM_NCMP = 8;
    localparam int CAM_NMCNT = 4;
    localparam int CAM_ADDR_W = 8;
    localparam int CAM_CLK_PERIOD_PS = 4000;
    localparam int CAM_WIDTH_UNIT_PS = 10000;
    localparam int CAM_US_PS = 1000000;
    localparam int CAM_CYCLES_PER_US = CAM_US_PS / CAM_CLK_PERIOD_PS;
    localparam logic [7:0] CAM_OFF_WCFG = 8'h00;
    localparam logic [7:0] CAM_OFF_WRES0 = 8'h04;
    localparam logic [7:0] CAM_OFF_ROUTE = 8'h14;
    localparam logic [7:0] CAM_OFF_SCTRL = 8'h18;
    localparam logic [7:0] CAM_OFF_SWIN0 = 8'h1C;
    localparam logic [7:0] CAM_OFF_SRES0 = 8'h2C;
    localparam logic [7:0] CAM_OFF_SSTAT = 8'h3C;
    localparam logic [7:0] CAM_OFF_CCTRL = 8'h40;
    localparam logic [7:0] CAM_OFF_CVAL = 8'h44;
    localparam logic [7:0] CAM_OFF_CSTAT = 8'h48;
    localparam int CAM_WCFG_EN_LSB = 0;
    localparam int CAM_WCFG_POL_LSB = 8;
    localparam int CAM_ROUTE_MASK_LSB = 0;
    localparam int CAM_ROUTE_CSEL_LSB = 8;
    localparam int CAM_CCTRL_EN_BIT = 0;
    localparam int CAM_CCTRL_CTR_LSB = 4;
    localparam int CAM_CCTRL_OUT_LSB = 8;
    localparam logic [31:0] CAM_RST_WORD = 32'h0000_0000;
    localparam logic [1:0] CAM_RESP_OKAY = 2'h0;
    localparam logic [1:0] CAM_RESP_SLVERR = 2'h2;

    // byte-lane merge of a write into the current register word
    function automatic logic [31:0] cam_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction : cam_merge
endpackage : cam_pkg

// file: design/cam_timed_sampling_unit.sv
// one timed sampling channel: pulses counted over a window in microseconds
`timescale 1ns/10ps
module cam_timed_sampling_unit (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic enable,
    input wire logic [31:0] window_us,
    input wire logic count_event,
    output logic [31:0] result,
    output logic done
);
    import cam_pkg::*;
    localparam logic [7:0] PRES_LAST = 8'(CAM_CYCLES_PER_US - 1);
    logic [7:0] pres_r;
    logic [31:0] us_r;
    logic [31:0] cnt_r;
    logic [31:0] cnt_plus;
    logic win_end;

    assign cnt_plus = cnt_r + {31'h0000_0000, count_event};
    assign win_end = (pres_r == PRES_LAST) && (us_r + 32'h1 == window_us);

    always_ff @(posedge aclk) begin
        if (!aresetn || !enable || window_us == 32'h0) begin
            pres_r <= 8'h00;
            us_r <= 32'h0000_0000;
            cnt_r <= 32'h0000_0000;
            result <= result;
            done <= 1'b0;
            if (!aresetn) begin
                result <= 32'h0000_0000;
            end
        end else begin
            pres_r <= (pres_r == PRES_LAST) ? 8'h00 : pres_r + 8'h01;
            done <= win_end;
            if (win_end) begin
                result <= cnt_plus;
                us_r <= 32'h0000_0000;
                cnt_r <= 32'h0000_0000;
            end else begin
                cnt_r <= cnt_plus;
                if (pres_r == PRES_LAST) begin
                    us_r <= us_r + 32'h0000_0001;
                end
            end
        end
    end

    samp_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (enable && win_end) |=> (done && result == $past(cnt_plus)))
        else $error("sample not latched at window end");
    samp_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !enable |=> (!done && cnt_r == 32'h0000_0000))
        else $error("sampling active while channel disabled");
endmodule : cam_timed_sampling_unit

// file: design/cam_width_measure_unit.sv
// one pulse-width measurement channel in 0.01us steps
`timescale 1ns/10ps
module cam_width_measure_unit (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic enable,
    input wire logic polarity,
    input wire logic pin_level,
    output logic [31:0] result
);
    import cam_pkg::*;
    localparam logic [15:0] STEP = 16'(CAM_CLK_PERIOD_PS);
    localparam logic [15:0] UNIT = 16'(CAM_WIDTH_UNIT_PS);
    logic [31:0] cnt_r;
    logic [15:0] acc_r;
    logic prev_r;
    logic active;

    assign active = polarity ? pin_level : ~pin_level;

    always_ff @(posedge aclk) begin
        if (!aresetn || !enable) begin
            cnt_r <= 32'h0000_0000;
            acc_r <= 16'h0000;
            prev_r <= 1'b0;
        end else begin
            prev_r <= active;
            if (active) begin
                if (17'(acc_r) + 17'(STEP) >= 17'(UNIT)) begin
                    acc_r <= acc_r + STEP - UNIT;
                    cnt_r <= cnt_r + 32'h0000_0001;
                end else begin
                    acc_r <= acc_r + STEP;
                end
            end else if (prev_r) begin
                cnt_r <= 32'h0000_0000;
                acc_r <= 16'h0000;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result <= 32'h0000_0000;
        end else if (enable && prev_r && !active) begin
            result <= cnt_r;
        end
    end

    width_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (enable && prev_r && !active) |=> (result == $past(cnt_r)))
        else $error("width result not taken from counter at pulse end");
    width_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !enable |=> (cnt_r == 32'h0000_0000))
        else $error("width counter runs while channel disabled");
endmodule : cam_width_measure_unit

// file: testbench/cam_counter_aux_measure_compare_bench.sv
// self-checking bench of the measure/compare block
`timescale 1ns/10ps
`define CK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
$display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module cam_counter_aux_measure_compare_bench;
    import cam_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, awready, wvalid = 1'b0, wready, bvalid;
    logic arvalid = 1'b0, arready, rvalid, bready = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic [3:0] wpin, evt;
    logic [7:0][31:0] cv = '0;
    logic [3:0][7:0] mm = '0;
    logic [7:0] flag, irq;
    int num_errors = 0, tests_run = 0;
    always #2 aclk = ~aclk;
    cam_pulse_source src (.aclk(aclk), .pin(wpin), .evt(evt));
    cam_counter_aux_measure_compare dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .width_pulse_input(wpin), .count_pulse(evt), .counter_value(cv),
        .multi_match(mm), .count_match_flag(flag), .compare_irq(irq));
    task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
        logic hb;
        hb = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!hb) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
            end
            hb = bvalid;
            r = bresp;
        end
        bready <= 1'b0;
        `CK(r, e)
    endtask : wr
    task rd(input logic [7:0] a, input logic [1:0] e);
        logic h;
        h = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!h) begin
            @(posedge aclk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
            end
            h = rvalid;
            d = rdata;
            r = rresp;
        end
        rready <= 1'b0;
        `CK(r, e)
    endtask : rd
    task t_map();
        rd(CAM_OFF_ROUTE, CAM_RESP_OKAY);
        `CK(d, CAM_RST_WORD)
        rd(8'h80, CAM_RESP_SLVERR);
        `CK(d, 32'h0)
        wr(8'h80, 32'h1, CAM_RESP_SLVERR);
    endtask : t_map
    task t_width();
        wr(CAM_OFF_WCFG, 32'h0000_0103, CAM_RESP_OKAY);
        src.level(0, 1'b1, 250);
        src.level(1, 1'b0, 125);
        src.level(2, 1'b1, 100);
        repeat (10) @(posedge aclk);
        rd(CAM_OFF_WRES0, CAM_RESP_OKAY);
        `CK(d >= 99 && d <= 101, 1'b1)
        rd(CAM_OFF_WRES0 + 8'h04, CAM_RESP_OKAY);
        `CK(d >= 49 && d <= 51, 1'b1)
        rd(CAM_OFF_WRES0 + 8'h08, CAM_RESP_OKAY);
        `CK(d, 32'h0)
    endtask : t_width
    task t_samp();
        wr(CAM_OFF_SWIN0, 32'h2, CAM_RESP_OKAY);
        wr(CAM_OFF_SCTRL, 32'h1, CAM_RESP_OKAY);
        src.burst(0, 7);
        repeat (500) @(posedge aclk);
        rd(CAM_OFF_SRES0, CAM_RESP_OKAY);
        `CK(d, 32'h7)
        rd(CAM_OFF_SSTAT, CAM_RESP_OKAY);
        `CK(d[0], 1'b1)
        repeat (500) @(posedge aclk);
        rd(CAM_OFF_SRES0, CAM_RESP_OKAY);
        `CK(d, 32'h0)
        wr(CAM_OFF_SSTAT, 32'h1, CAM_RESP_OKAY);
        rd(CAM_OFF_SSTAT, CAM_RESP_OKAY);
        `CK(d[0], 1'b0)
        wr(CAM_OFF_SCTRL, 32'h0, CAM_RESP_OKAY);
    endtask : t_samp
    task t_cmp();
        wr(CAM_OFF_CVAL, 32'h5, CAM_RESP_OKAY);
        cv[2] <= 32'h5;
        for (int o = 0; o < 8; o++) begin
            wr(CAM_OFF_CCTRL, 32'h0, CAM_RESP_OKAY);
            repeat (3) @(posedge aclk);
            `CK(flag, 8'h00)
            wr(CAM_OFF_CCTRL, 32'h21 | (o << 8), CAM_RESP_OKAY);
            repeat (3) @(posedge aclk);
            `CK(flag, 8'h01 << o)
            `CK(irq, 8'h01 << o)
        end
        rd(CAM_OFF_CSTAT, CAM_RESP_OKAY);
        `CK(d, 32'h80)
        cv[2] <= 32'h6;
        repeat (3) @(posedge aclk);
        `CK(flag, 8'h00)
    endtask : t_cmp
    task t_route();
        mm <= {8'h08, 8'h04, 8'h02, 8'h01};
        for (int c = 0; c < 4; c++) begin
            wr(CAM_OFF_ROUTE, 32'hFF | (c << 8), CAM_RESP_OKAY);
            repeat (2) @(posedge aclk);
            `CK(irq, 8'h01 << c)
        end
    endtask : t_route
    task test_done();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    initial begin
        #200000;
        num_errors++;
        test_done();
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_map();
        t_width();
        t_samp();
        t_cmp();
        t_route();
        test_done();
    end
endmodule : cam_counter_aux_measure_compare_bench

// file: testbench/cam_pulse_source.sv
// partner model: external width pins and counted pulse events
`timescale 1ns/10ps
module cam_pulse_source (
    input wire logic aclk,
    output logic [cam_pkg::CAM_WCH-1:0] pin,
    output logic [cam_pkg::CAM_SCH-1:0] evt
);
    import cam_pkg::*;
    initial begin
        pin = 4'h2;
        evt = 4'h0;
    end
    // one level of n cycles on a dedicated width pin, then back
    task automatic level(input int ch, input logic lv, input int n);
        @(posedge aclk);
        pin[ch] <= lv;
        repeat (n) @(posedge aclk);
        pin[ch] <= ~lv;
    endtask : level
    // every pulse format reaches the block as one event a pulse
    task automatic burst(input int ch, input int n);
        repeat (n) begin
            @(posedge aclk);
            evt[ch] <= 1'b1;
            @(posedge aclk);
            evt[ch] <= 1'b0;
        end
    endtask : burst
endmodule : cam_pulse_source
